/* common/gpio_port_pkg.sv */
package gpio_port_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W             = 4;
	localparam logic [3:0]  OFS_PIN_LEVELS     = 4'h0;
	localparam logic [3:0]  OFS_DIRECTION      = 4'h1;
	localparam logic [3:0]  OFS_LATCH          = 4'h2;
	localparam logic [3:0]  OFS_ANALOG_SELECT  = 4'h3;
	localparam logic [3:0]  OFS_PERIPH_ENABLE  = 4'h4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0]  RST_DIRECTION      = 8'hff;
	localparam logic [7:0]  RST_ANALOG_SELECT  = 8'hff;
	localparam logic [7:0]  RST_PERIPH_ENABLE  = 8'h00;
	localparam logic [7:0]  RST_LATCH_POWERON  = 8'h00;

	// ****************************************
	// Peripheral enable field positions
	// ****************************************
	localparam int          PEN_LCD            = 0;
	localparam int          PEN_PWM            = 1;
	localparam int          PEN_CAPTURE4       = 2;

	// ****************************************
	// Input synchroniser timing
	// ****************************************
	localparam int          SYNC_STAGES        = 3;

	typedef enum logic [1:0] {
		SRC_PORT,
		SRC_PWM,
		SRC_LCD
	} pin_source_t;

endpackage : gpio_port_pkg

/* core/gpio_port.sv */
// How it works
// - Eight pins; direction one means high-impedance input.
// - Direction zero drives latch onto pin.
// - Data read gives pins; write goes latch.
// - Port write loads the written byte straight into latch.
// - Direction bits gate drivers even when analog.
// - Analog pins read zero on data reads.
// - Analog select gates digital input to zero.
// - Analog select never affects digital output.
// - Analog select bits reset to analog.
// - Highest enabled output function owns the pin.
// - Pins 0-2: common3, capture4, pwm2 b over port.
// - Pins 3-7: segments, then pwm outputs, then port.
// - Input functions stay live while pin outputs.
// - Absent port reads zero everywhere.
// - Latch survives non-power-on resets.
// - Direction bits reset to one always.
// - Separate latch register readable and writable.
// - Analog select zero gives digital I/O.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/100ps
module gpio_port
	import gpio_port_pkg::*;
#(
	parameter bit PORT_PRESENT = 1'b1
) (
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              por_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [7:0]        wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [7:0]        rdata_out,
	input  wire logic [7:0]        pin_in,
	output logic      [7:0]        pin_out,
	output logic      [7:0]        pin_oe_out,
	output logic      [7:0]        digital_in_out,
	output logic      [7:0]        analog_enable_out,
	input  wire logic              lcd_common_line_3_in,
	input  wire logic [4:0]        lcd_segment_line_in,
	input  wire logic              capture_compare_unit_4_in,
	input  wire logic              pwm2_output_b_in,
	input  wire logic              pwm2_output_c_in,
	input  wire logic              pwm2_output_d_in,
	input  wire logic              pwm1_output_b_in,
	input  wire logic              pwm1_output_c_in,
	input  wire logic              pwm1_output_d_in
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] pin_direction_bits_r;
	logic [7:0] output_latch_bits_r;
	logic [7:0] analog_select_bits_r;
	logic [7:0] periph_enable_r;
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] sync3_r;
	logic [7:0] pin_level_r;
	logic [7:0] rdata_r;

	// ****************************************
	// Decode
	// ****************************************
	wire logic       sel_levels  = (addr_in == OFS_PIN_LEVELS);
	wire logic       sel_dir     = (addr_in == OFS_DIRECTION);
	wire logic       sel_latch   = (addr_in == OFS_LATCH);
	wire logic       sel_analog  = (addr_in == OFS_ANALOG_SELECT);
	wire logic       sel_pen     = (addr_in == OFS_PERIPH_ENABLE);
	wire logic       lcd_en      = periph_enable_r[PEN_LCD];
	wire logic       pwm_en      = periph_enable_r[PEN_PWM];
	wire logic       capture4_en = periph_enable_r[PEN_CAPTURE4];
	wire logic       sel_any     = sel_levels | sel_dir | sel_latch | sel_analog | sel_pen;
	wire logic [7:0] level_agree = ~(sync2_r ^ sync3_r);
	wire logic [7:0] digital_rd  = pin_level_r & ~analog_select_bits_r;
	wire logic [7:0] rmw_value   = wdata_in;
	logic      [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		if (sel_levels)
			rd_mux = digital_rd;
		else if (sel_dir)
			rd_mux = pin_direction_bits_r;
		else if (sel_latch)
			rd_mux = output_latch_bits_r;
		else if (sel_analog)
			rd_mux = analog_select_bits_r;
		else if (sel_pen)
			rd_mux = periph_enable_r;
	end

	// ****************************************
	// Pin input synchroniser
	// ****************************************
	// Level sampling
	always_ff @(posedge clk_in) begin
		sync1_r <= pin_in;
		sync2_r <= sync1_r;
		sync3_r <= sync2_r;
	end

	// A bit only changes once two stages agree, rejecting a one-cycle glitch
	generate
		for (genvar i = 0; i < 8; i++) begin : g_filt
			always_ff @(posedge clk_in) begin
				if (rst_in)
					pin_level_r[i] <= 1'b0;
				else if (sync2_r[i] == sync3_r[i])
					pin_level_r[i] <= sync3_r[i];
			end
		end
	endgenerate

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pin_direction_bits_r <= RST_DIRECTION;
			analog_select_bits_r <= RST_ANALOG_SELECT;
			periph_enable_r      <= RST_PERIPH_ENABLE;
		end else if (wr_in && PORT_PRESENT) begin
			if (sel_dir)
				pin_direction_bits_r <= wdata_in;
			if (sel_analog)
				analog_select_bits_r <= wdata_in;
			if (sel_pen)
				periph_enable_r <= wdata_in;
		end
	end

	// Latch is only forced on power-on reset; other resets keep it
	always_ff @(posedge clk_in) begin
		if (por_in)
			output_latch_bits_r <= RST_LATCH_POWERON;
		else if (wr_in && PORT_PRESENT && (sel_levels || sel_latch))
			output_latch_bits_r <= rmw_value;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			rdata_r <= 8'h00;
		else if (rd_in)
			rdata_r <= PORT_PRESENT ? rd_mux : 8'h00;
	end
	assign rdata_out = rdata_r;

	// ****************************************
	// Output priority mux
	// ****************************************
	logic [7:0]        periph_own;
	logic [7:0]        periph_val;
	logic [4:0]        pwm_hi;
	assign pwm_hi = {pwm1_output_d_in, pwm1_output_c_in, pwm1_output_b_in, pwm2_output_d_in, pwm2_output_c_in};

	always_comb begin
		periph_own    = 8'h00;
		periph_val    = 8'h00;
		periph_own[0] = lcd_en;
		periph_val[0] = lcd_common_line_3_in;
		periph_own[1] = capture4_en;
		periph_val[1] = capture_compare_unit_4_in;
		periph_own[2] = pwm_en;
		periph_val[2] = pwm2_output_b_in;
		for (int k = 0; k < 5; k++) begin
			periph_own[k+3] = lcd_en | pwm_en;
			periph_val[k+3] = lcd_en ? lcd_segment_line_in[k] : pwm_hi[k];
		end
	end

	assign pin_out = PORT_PRESENT ? ((periph_own & periph_val) | (~periph_own & output_latch_bits_r)) : 8'h00;
	assign pin_oe_out = PORT_PRESENT ? ~pin_direction_bits_r : 8'h00;
	assign digital_in_out    = digital_rd;
	assign analog_enable_out = analog_select_bits_r;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	chk_analog_read_zero: assert property (
		rd_in && sel_levels |=> (rdata_out & $past(analog_select_bits_r)) == 8'h00)
		else $error("analog pin read nonzero");
	chk_dir_reset_ones: assert property (
		$fell(rst_in) |-> pin_direction_bits_r == RST_DIRECTION)
		else $error("direction not reset");
	chk_analog_reset: assert property (
		$fell(rst_in) |-> analog_select_bits_r == RST_ANALOG_SELECT)
		else $error("analog select not reset");
	chk_port_write_latch: assert property (
		wr_in && sel_levels && !por_in && PORT_PRESENT |=> output_latch_bits_r == $past(wdata_in))
		else $error("port write missed latch");
	chk_oe_direction: assert property (
		pin_oe_out == ~pin_direction_bits_r)
		else $error("enable disagrees with direction");
	chk_pin0_common: assert property (
		lcd_en |-> pin_out[0] == lcd_common_line_3_in)
		else $error("pin 0 priority wrong");
	chk_pin3_segment: assert property (
		lcd_en |-> pin_out[3] == lcd_segment_line_in[0])
		else $error("pin 3 priority wrong");
	chk_latch_fallback: assert property (
		periph_enable_r == 8'h00 |-> pin_out == output_latch_bits_r)
		else $error("latch not on pins");
	chk_read_latency: assert property (
		rd_in && sel_latch ##1 !$past(wr_in) |-> rdata_out == output_latch_bits_r)
		else $error("latch read wrong");

	// ****************************************
	// Reset and latch checks
	// ****************************************
	// Power-on latch clear
	// Power-on only happens inside reset, so this one watches through it
	chk_latch_poweron: assert property (
		@(posedge clk_in) disable iff (1'b0)
		por_in |=> output_latch_bits_r == RST_LATCH_POWERON)
		else $error("latch not cleared at power-on");

	chk_latch_kept_reset: assert property (
		@(posedge clk_in) disable iff (por_in)
		rst_in && !wr_in |=> $stable(output_latch_bits_r))
		else $error("latch lost over reset");

	// ****************************************
	// Register bus checks
	// ****************************************
	// Direction write lands
	chk_dir_write: assert property (
		wr_in && sel_dir && PORT_PRESENT
		|=> pin_direction_bits_r == $past(wdata_in))
		else $error("direction write lost");

	chk_analog_write: assert property (
		wr_in && sel_analog && PORT_PRESENT
		|=> analog_select_bits_r == $past(wdata_in))
		else $error("analog select write lost");

	chk_absent_read_zero: assert property (
		rd_in && !PORT_PRESENT
		|=> rdata_out == 8'h00)
		else $error("absent port read nonzero");

	chk_unmapped_read: assert property (
		rd_in && !sel_any
		|=> rdata_out == 8'h00)
		else $error("unmapped read nonzero");

	chk_read_hold: assert property (
		!rd_in
		|=> $stable(rdata_out))
		else $error("read data moved without read");

	// ****************************************
	// Input path checks
	// ****************************************
	// Agreeing stages pass
	chk_filter_follow: assert property (
		1'b1
		|=> ((pin_level_r ^ $past(sync3_r)) & $past(level_agree)) == 8'h00)
		else $error("filtered level missed change");

	chk_filter_hold: assert property (
		1'b1
		|=> ((pin_level_r ^ $past(pin_level_r)) & ~$past(level_agree)) == 8'h00)
		else $error("filtered level took glitch");

	chk_digital_gate: assert property (
		1'b1
		|-> (digital_in_out & analog_select_bits_r) == 8'h00)
		else $error("analog pin seen as digital");

	chk_analog_enable: assert property (
		1'b1
		|-> analog_enable_out == analog_select_bits_r)
		else $error("analog enable wrong");

	// ****************************************
	// Output mux checks
	// ****************************************
	// Pin 1 capture unit
	chk_pin1_capture: assert property (
		capture4_en
		|-> pin_out[1] == capture_compare_unit_4_in)
		else $error("pin 1 priority wrong");

	chk_pin2_pwm: assert property (
		pwm_en
		|-> pin_out[2] == pwm2_output_b_in)
		else $error("pin 2 priority wrong");

	chk_pin5_pwm: assert property (
		pwm_en && !lcd_en
		|-> pin_out[5] == pwm1_output_b_in)
		else $error("pin 5 priority wrong");

	chk_pin7_pwm: assert property (
		pwm_en && !lcd_en
		|-> pin_out[7] == pwm1_output_d_in)
		else $error("pin 7 priority wrong");

	// ****************************************
	// Coverage
	// ****************************************

	cov_digital_read: cover property (rd_in && sel_levels && analog_select_bits_r == 8'h00);
	cov_output_drive: cover property (pin_oe_out == 8'hff);
	cov_pwm_only: cover property (pwm_en && !lcd_en);
	cov_lcd_pwm: cover property (pwm_en && lcd_en);
	cov_mid_reset: cover property ($fell(rst_in) && !$past(por_in));

endmodule : gpio_port

/* verif/gpio_pin_model.sv */
`timescale 1ns/100ps
module gpio_pin_model (
	input  wire logic [7:0] drive_in,
	input  wire logic [7:0] oe_in,
	input  wire logic [7:0] ext_level_in,
	output logic      [7:0] level_out
);
	// ****************************************
	// Pin wire
	// ****************************************
	// per-pin resolve
	// Outside drivers only win on pins the port leaves floating
	assign level_out = (oe_in & drive_in) | (~oe_in & ext_level_in);
endmodule : gpio_pin_model

/* verif/bidirectional_gpio_port_d_tb.sv */
`timescale 1ns/100ps
module bidirectional_gpio_port_d_tb;
	import gpio_port_pkg::*;
	logic              clk_in, rst_in, por_in, wr_in, rd_in, common3, capture4, pwm2b;
	logic [7:0]        absent_rdata, absent_pin, absent_oe;
	logic [ADDR_W-1:0] addr_in;
	logic [7:0]        wdata_in, rdata_out, pin_level, pin_out, pin_oe_out, ext_level, exp, dig, ana;
	logic [4:0]        seg, pwm;
	logic [2:0]        en;
	int                fail_count, total_checks, cycles;

	gpio_port DUT (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_level),
		.pin_out(pin_out), .pin_oe_out(pin_oe_out), .digital_in_out(dig), .analog_enable_out(ana),
		.lcd_common_line_3_in(common3), .lcd_segment_line_in(seg), .capture_compare_unit_4_in(capture4),
		.pwm2_output_b_in(pwm2b), .pwm2_output_c_in(pwm[0]), .pwm2_output_d_in(pwm[1]),
		.pwm1_output_b_in(pwm[2]), .pwm1_output_c_in(pwm[3]), .pwm1_output_d_in(pwm[4]));
	gpio_pin_model pins (.drive_in(pin_out), .oe_in(pin_oe_out), .ext_level_in(ext_level),
		.level_out(pin_level));
	// Variant without the port, on the same bus
	gpio_port #(.PORT_PRESENT(1'b0)) DUT_ABSENT (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(absent_rdata),
		.pin_in(pin_level), .pin_out(absent_pin), .pin_oe_out(absent_oe), .digital_in_out(),
		.analog_enable_out(), .lcd_common_line_3_in(common3), .lcd_segment_line_in(seg),
		.capture_compare_unit_4_in(capture4), .pwm2_output_b_in(pwm2b), .pwm2_output_c_in(pwm[0]),
		.pwm2_output_d_in(pwm[1]), .pwm1_output_b_in(pwm[2]), .pwm1_output_c_in(pwm[3]),
		.pwm1_output_d_in(pwm[4]));

	// ****************************************
	// Tasks
	// ****************************************
	task chk(input logic [7:0] got, input logic [7:0] want);
		total_checks++;
		if (got !== want) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] want);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, want);
	endtask : rd
	task give_verdict;
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			give_verdict();
		end
	end

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		{rst_in, por_in, wr_in, rd_in, addr_in, wdata_in} = {2'b11, 2'b00, 4'h0, 8'h00};
		{common3, capture4, pwm2b, seg, pwm, ext_level} = {3'b111, 5'h16, 5'h0d, 8'ha5};
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		por_in <= 1'b0;
		rd(OFS_DIRECTION, RST_DIRECTION);
		rd(OFS_ANALOG_SELECT, RST_ANALOG_SELECT);
		rd(OFS_LATCH, RST_LATCH_POWERON);
		chk(ana, 8'hff);
		chk(pin_oe_out, 8'h00);
		rd(OFS_PIN_LEVELS, 8'h00);
		wr(OFS_ANALOG_SELECT, 8'h00);
		repeat (8) @(posedge clk_in);
		rd(OFS_PIN_LEVELS, 8'ha5);
		chk(dig, 8'ha5);
		wr(OFS_PIN_LEVELS, 8'h3c);
		rd(OFS_LATCH, 8'h3c);
		rd(OFS_PIN_LEVELS, 8'ha5);
		wr(OFS_DIRECTION, 8'h00);
		chk(pin_oe_out, 8'hff);
		chk(pin_out, 8'h3c);
		repeat (8) @(posedge clk_in);
		rd(OFS_PIN_LEVELS, 8'h3c);
		wr(OFS_ANALOG_SELECT, 8'hf0);
		repeat (3) @(posedge clk_in);
		rd(OFS_PIN_LEVELS, 8'h0c);
		chk(dig, 8'h0c);
		chk(pin_out, 8'h3c);
		wr(OFS_LATCH, 8'h00);
		for (int i = 0; i < 8; i++) begin
			en = i[2:0];
			wr(OFS_PERIPH_ENABLE, {5'h00, en});
			exp = {en[0] ? seg : (en[1] ? pwm : 5'h00), en[1] & pwm2b, en[2] & capture4, en[0] & common3};
			chk(pin_out, exp);
		end
		wr(OFS_PERIPH_ENABLE, 8'h00);
		wr(OFS_DIRECTION, 8'h0f);
		chk(pin_oe_out, 8'hf0);
		wr(4'hf, 8'h55);
		rd(4'hf, 8'h00);
		rd(OFS_DIRECTION, 8'h0f);
		chk(absent_rdata, 8'h00);
		chk(absent_oe, 8'h00);
		chk(absent_pin, 8'h00);
		wr(OFS_LATCH, 8'h5a);
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(OFS_LATCH, 8'h5a);
		rd(OFS_DIRECTION, RST_DIRECTION);
		give_verdict();
	end
endmodule : bidirectional_gpio_port_d_tb
